// ---- core/plss_link_track.sv ----
`timescale 1ns/1ps
module plss_link_track (
	input wire logic mclk,
	input wire logic reset,
	input wire logic train_start,
	input wire logic retrain,
	input wire logic train_fail,
	input wire logic train_done,
	input wire logic [plss_pkg::SPEED_W-1:0] speed_in,
	input wire logic [plss_pkg::WIDTH_W-1:0] width_in,
	output logic training,
	output logic train_err,
	output logic [plss_pkg::SPEED_W-1:0] speed,
	output logic [plss_pkg::WIDTH_W-1:0] width
);
	import plss_pkg::*;

	typedef enum logic [1:0] {
		TRN_IDLE = 2'b01,
		TRN_BUSY = 2'b10
	} plss_trn_e;

	plss_trn_e state_q;

	// ****************************************
	// training state
	// ****************************************
	// busy until done or fail
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= TRN_IDLE;
		end else begin
			unique case (state_q)
				TRN_IDLE: begin
					if ((train_start || retrain) && !train_done && !train_fail) begin
						state_q <= TRN_BUSY;
					end
				end
				TRN_BUSY: begin
					if (train_done || train_fail) begin
						state_q <= TRN_IDLE;
					end
				end
			endcase
		end
	end

	assign training = (state_q == TRN_BUSY);

	always_ff @(posedge mclk) begin
		if (reset) begin
			train_err <= 1'b0;
		end else if (train_fail) begin
			// set beats clear when both land together
			train_err <= 1'b1;
		end else if (train_done) begin
			train_err <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			speed <= SPEED_RESET;
			width <= WIDTH_RESET;
		end else if (train_done) begin
			speed <= speed_in;
			width <= width_in;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_ERR_SET: assert property (@(posedge mclk) disable iff (reset)
		train_fail |=> train_err)
		else $error("training error not set after failure");
	AST_ERR_CLR: assert property (@(posedge mclk) disable iff (reset)
		train_done && !train_fail |=> !train_err)
		else $error("training error not cleared after success");
	AST_TRN_CLR: assert property (@(posedge mclk) disable iff (reset)
		train_done |=> !training)
		else $error("training flag held after completion");
	AST_TRN_SET: assert property (@(posedge mclk) disable iff (reset)
		(train_start || retrain) && !train_done && !train_fail |=> training)
		else $error("training flag not raised");
	AST_SPEED_RESET: assert property (@(posedge mclk)
		reset |=> speed == SPEED_RESET && width == WIDTH_RESET)
		else $error("speed or width reset value wrong");
endmodule

// ---- core/plss_pkg.sv ----
package plss_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_LINK_STATE = 8'hd0;
	localparam logic [7:0] OFF_SLOT_CAP = 8'hd4;

	// ****************************************
	// link state report fields
	// ****************************************
	localparam int SPEED_LSB = 16;
	localparam int SPEED_W = 4;
	localparam int WIDTH_LSB = 20;
	localparam int WIDTH_W = 6;
	localparam int TRAIN_ERR_BIT = 26;
	localparam int TRAINING_BIT = 27;
	localparam int SLOT_CLK_BIT = 28;
	localparam int DL_ACTIVE_BIT = 29;
	localparam int RETRAIN_BIT = 5;
	localparam logic [3:0] SPEED_2G5 = 4'h1;
	localparam logic [3:0] SPEED_5G = 4'h2;
	localparam logic [3:0] SPEED_RESET = SPEED_5G;
	localparam logic [5:0] WIDTH_RESET = 6'h01;

	// ****************************************
	// slot capability fields
	// ****************************************
	localparam logic [31:0] CAPS_RESET = 32'h0000_0000;
	// bits 31:19, 16:0 without bit 2
	localparam logic [31:0] CAPS_IMPL_MASK = 32'hfff9_fffb;
	// power limit value 14:7 and scale 16:15
	localparam logic [31:0] CAPS_SW_MASK = 32'h0001_ff80;
endpackage

// ---- core/plss_port_link_slot.sv ----
`timescale 1ns/1ps
module plss_port_link_slot #(
	parameter bit IS_DOWNSTREAM = 1'b1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic slot_clock_strap,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [plss_pkg::ADDR_W-1:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [plss_pkg::DATA_W-1:0] cfg_wdata,
	output logic [plss_pkg::DATA_W-1:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic ovr_wr,
	input wire logic [plss_pkg::ADDR_W-1:0] ovr_addr,
	input wire logic [plss_pkg::DATA_W-1:0] ovr_wdata,
	input wire logic link_train_start,
	input wire logic link_train_fail,
	input wire logic link_train_done,
	input wire logic [plss_pkg::SPEED_W-1:0] link_speed_in,
	input wire logic [plss_pkg::WIDTH_W-1:0] link_width_in,
	input wire logic dl_active_in,
	output logic retrain_req,
	output logic spl_msg_req
);
	import plss_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	logic slot_clk_q;
	logic dl_active_q;
	logic [31:0] caps_q;
	logic [31:0] link_word;
	logic [31:0] wmask;
	logic sw_caps_wr;
	logic sw_spl_wr;
	logic ovr_caps_wr;
	logic trk_training;
	logic trk_err;
	logic [SPEED_W-1:0] trk_speed;
	logic [WIDTH_W-1:0] trk_width;

	assign wmask = be_mask(cfg_be);
	assign sw_caps_wr = IS_DOWNSTREAM && cfg_wr && (cfg_addr == OFF_SLOT_CAP);
	assign sw_spl_wr = sw_caps_wr && ((wmask & CAPS_SW_MASK) != 32'h0000_0000);
	assign ovr_caps_wr = IS_DOWNSTREAM && ovr_wr && (ovr_addr == OFF_SLOT_CAP);

	// ****************************************
	// link training tracker
	// ****************************************
	plss_link_track u_track (
		.mclk(mclk),
		.reset(reset),
		.train_start(link_train_start),
		.retrain(retrain_req),
		.train_fail(link_train_fail),
		.train_done(link_train_done),
		.speed_in(link_speed_in),
		.width_in(link_width_in),
		.training(trk_training),
		.train_err(trk_err),
		.speed(trk_speed),
		.width(trk_width)
	);

	// ****************************************
	// retrain request
	// ****************************************
	// downstream retrain write
	always_ff @(posedge mclk) begin
		if (reset) begin
			retrain_req <= 1'b0;
		end else begin
			retrain_req <= IS_DOWNSTREAM && cfg_wr && (cfg_addr == OFF_LINK_STATE) &&
				cfg_be[0] && cfg_wdata[RETRAIN_BIT];
		end
	end

	// ****************************************
	// slot clock and link active
	// ****************************************
	// strap caught at reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			// synchronous reset, so the strap level is sampled by the clock
			slot_clk_q <= slot_clock_strap;
		end else if (ovr_wr && (ovr_addr == OFF_LINK_STATE)) begin
			slot_clk_q <= ovr_wdata[SLOT_CLK_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			dl_active_q <= 1'b0;
		end else begin
			dl_active_q <= dl_active_in;
		end
	end

	// ****************************************
	// slot capability register
	// ****************************************
	// software writes only the power limit value and scale, the rest is read-only
	always_ff @(posedge mclk) begin
		if (reset) begin
			caps_q <= CAPS_RESET;
		end else if (ovr_caps_wr) begin
			// sideband wins, it programs board defaults
			caps_q <= ovr_wdata & CAPS_IMPL_MASK;
		end else if (sw_caps_wr) begin
			caps_q <= merge(caps_q, cfg_wdata, wmask & CAPS_SW_MASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			spl_msg_req <= 1'b0;
		end else begin
			spl_msg_req <= sw_spl_wr;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// reserved and link control half zero
	assign link_word = {2'b00, dl_active_q, slot_clk_q, trk_training, trk_err,
		trk_width, trk_speed, 16'h0000};

	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_rvalid <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				if (cfg_addr == OFF_LINK_STATE) begin
					cfg_rdata <= link_word;
				end else if (IS_DOWNSTREAM && (cfg_addr == OFF_SLOT_CAP)) begin
					cfg_rdata <= caps_q;
				end else begin
					cfg_rdata <= 32'h0000_0000;
				end
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_SPL_MSG: assert property (@(posedge mclk) disable iff (reset)
		sw_spl_wr |=> spl_msg_req ##1 !spl_msg_req || $past(sw_spl_wr))
		else $error("slot power message not requested");
	AST_NO_SPL_MSG: assert property (@(posedge mclk) disable iff (reset)
		!sw_spl_wr |=> !spl_msg_req)
		else $error("spurious slot power message");
	AST_UPSTREAM_CAPS: assert property (@(posedge mclk) disable iff (reset)
		!IS_DOWNSTREAM && cfg_rd && cfg_addr == OFF_SLOT_CAP |=> cfg_rdata == 32'h0000_0000)
		else $error("upstream port exposes slot_capability_info");
	AST_DL_ACTIVE: assert property (@(posedge mclk) disable iff (reset)
		cfg_rd && cfg_addr == OFF_LINK_STATE && !$past(reset) |=>
		cfg_rdata[DL_ACTIVE_BIT] == $past(dl_active_in, 2))
		else $error("link active bit does not follow data link state");
	AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (reset)
		cfg_rvalid |-> ($past(cfg_addr) != OFF_LINK_STATE || cfg_rdata[31:30] == 2'b00) &&
		($past(cfg_addr) != OFF_SLOT_CAP || (cfg_rdata[18:17] == 2'b00 && !cfg_rdata[2])))
		else $error("reserved bits read nonzero");
	AST_RO_CAPS: assert property (@(posedge mclk) disable iff (reset)
		sw_caps_wr && !ovr_caps_wr |=> (caps_q & ~CAPS_SW_MASK) == $past(caps_q & ~CAPS_SW_MASK))
		else $error("software changed a read-only capability field");
	AST_RETRAIN: assert property (@(posedge mclk) disable iff (reset)
		retrain_req && !link_train_done && !link_train_fail |=> trk_training)
		else $error("retrain did not start training");
	AST_RETRAIN_REQ: assert property (@(posedge mclk) disable iff (reset)
		cfg_wr && cfg_addr == OFF_LINK_STATE && cfg_be[0] && cfg_wdata[RETRAIN_BIT] |=>
		retrain_req == IS_DOWNSTREAM)
		else $error("retrain request does not follow control write");
	AST_STRAP: assert property (@(posedge mclk)
		reset |=> slot_clk_q == $past(slot_clock_strap))
		else $error("slot clock bit does not follow strap in reset");
	AST_CLK_OVR: assert property (@(posedge mclk) disable iff (reset)
		ovr_wr && ovr_addr == OFF_LINK_STATE |=>
		slot_clk_q == $past(ovr_wdata[SLOT_CLK_BIT]))
		else $error("sideband did not set slot clock bit");
	AST_CAPS_OVR: assert property (@(posedge mclk) disable iff (reset)
		ovr_caps_wr |=> caps_q == $past(ovr_wdata & CAPS_IMPL_MASK))
		else $error("sideband did not load slot_capability_info");
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
	import plss_pkg::*;
	logic mclk, reset, strap, wr, rd, ovr, tst, tfl, tdn, dla;
	logic [7:0] addr;
	logic [3:0] be, spd;
	logic [5:0] wid;
	logic [31:0] wd, rdata, rdata_up, got, got_up;
	logic rvalid, rvalid_up, rtr, rtr_up, spl, spl_up, seen_spl, seen_rtr;
	int n_mismatch, compares;

	// ****************************************
	// downstream and upstream ports on shared stimulus
	// ****************************************
	plss_port_link_slot DUT (.mclk(mclk), .reset(reset), .slot_clock_strap(strap),
		.cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd),
		.cfg_rdata(rdata), .cfg_rvalid(rvalid), .ovr_wr(ovr), .ovr_addr(addr),
		.ovr_wdata(wd), .link_train_start(tst), .link_train_fail(tfl),
		.link_train_done(tdn), .link_speed_in(spd), .link_width_in(wid),
		.dl_active_in(dla), .retrain_req(rtr), .spl_msg_req(spl));
	plss_port_link_slot #(.IS_DOWNSTREAM(1'b0)) dut_up (.mclk(mclk), .reset(reset),
		.slot_clock_strap(strap), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr), .cfg_be(be),
		.cfg_wdata(wd), .cfg_rdata(rdata_up), .cfg_rvalid(rvalid_up), .ovr_wr(ovr),
		.ovr_addr(addr), .ovr_wdata(wd), .link_train_start(tst), .link_train_fail(tfl),
		.link_train_done(tdn), .link_speed_in(spd), .link_width_in(wid),
		.dl_active_in(dla), .retrain_req(rtr_up), .spl_msg_req(spl_up));

	// ****************************************
	// compare and access tasks
	// ****************************************
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic seen);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", what, exp, seen);
		end
	endtask
	// flags are {link active, clock source, training, error}
	function automatic logic [31:0] lw(input logic [3:0] f, input logic [5:0] w,
		input logic [3:0] s);
		return {2'b00, f, w, s, 16'h0000};
	endfunction
	task automatic rd_reg(input logic [7:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk_bit("read valid", 1'b1, rvalid);
		chk_bit("upstream read valid", 1'b1, rvalid_up);
		got = rdata;
		got_up = rdata_up;
	endtask
	// sb selects the sideband load path instead of software
	task automatic wr_reg(input logic sb, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge mclk);
		if (sb) begin
			ovr <= 1'b1;
		end else begin
			wr <= 1'b1;
		end
		addr <= a;
		be <= b;
		wd <= d;
		@(posedge mclk);
		wr <= 1'b0;
		ovr <= 1'b0;
		#1;
		seen_spl = spl;
		seen_rtr = rtr;
	endtask
	// w is {start, fail, done}; speed and width ride along with it
	task automatic ev(input logic [2:0] w, input logic [3:0] s, input logic [5:0] n);
		@(posedge mclk);
		{tst, tfl, tdn} <= w;
		spd <= s;
		wid <= n;
		@(posedge mclk);
		{tst, tfl, tdn} <= 3'b000;
	endtask
	task automatic conclude();
		$display("compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************
	// clock, watchdog and test sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// whole run is well under 200 cycles
	initial begin
		repeat (3000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		{reset, strap, wr, rd, ovr, tst, tfl, tdn, dla} = 9'h180;
		addr = 8'h00;
		be = 4'h0;
		wd = 32'h0;
		spd = 4'h2;
		wid = 6'h01;
		n_mismatch = 0;
		compares = 0;
		repeat (4) @(posedge mclk);
		// strap drops with reset so only the reset-time level may show
		reset <= 1'b0;
		strap <= 1'b0;
		rd_reg(OFF_LINK_STATE);
		chk_word("link reset", lw(4'b0100, 6'h01, 4'h2), got);
		rd_reg(OFF_SLOT_CAP);
		chk_word("caps reset", 32'h0, got);
		rd_reg(8'hd8);
		chk_word("unmapped", 32'h0, got);
		wr_reg(1'b0, OFF_LINK_STATE, 4'hf, 32'hffff_ffff);
		chk_bit("retrain pulse", 1'b1, seen_rtr);
		chk_bit("upstream retrain", 1'b0, rtr_up);
		rd_reg(OFF_LINK_STATE);
		chk_word("link retraining", lw(4'b0110, 6'h01, 4'h2), got);
		chk_word("upstream no retrain", lw(4'b0100, 6'h01, 4'h2), got_up);
		ev(3'b001, 4'h1, 6'h04);
		rd_reg(OFF_LINK_STATE);
		chk_word("link trained", lw(4'b0100, 6'h04, 4'h1), got);
		ev(3'b010, 4'h1, 6'h04);
		rd_reg(OFF_LINK_STATE);
		chk_word("link failed", lw(4'b0101, 6'h04, 4'h1), got);
		ev(3'b100, 4'h1, 6'h04);
		rd_reg(OFF_LINK_STATE);
		chk_word("link restart", lw(4'b0111, 6'h04, 4'h1), got);
		ev(3'b001, 4'h2, 6'h02);
		rd_reg(OFF_LINK_STATE);
		chk_word("link recovered", lw(4'b0100, 6'h02, 4'h2), got);
		@(posedge mclk);
		dla <= 1'b1;
		rd_reg(OFF_LINK_STATE);
		chk_word("link active", lw(4'b1100, 6'h02, 4'h2), got);
		@(posedge mclk);
		dla <= 1'b0;
		rd_reg(OFF_LINK_STATE);
		chk_word("link inactive", lw(4'b0100, 6'h02, 4'h2), got);
		wr_reg(1'b0, OFF_SLOT_CAP, 4'hf, 32'hffff_ffff);
		chk_bit("power message", 1'b1, seen_spl);
		chk_bit("upstream message", 1'b0, spl_up);
		rd_reg(OFF_SLOT_CAP);
		chk_word("caps written", 32'h0001_ff80, got);
		chk_word("upstream caps", 32'h0, got_up);
		// top byte holds no power field, so no message
		wr_reg(1'b0, OFF_SLOT_CAP, 4'h8, 32'h0);
		chk_bit("no message", 1'b0, seen_spl);
		wr_reg(1'b0, OFF_SLOT_CAP, 4'h1, 32'h0);
		chk_bit("low byte message", 1'b1, seen_spl);
		rd_reg(OFF_SLOT_CAP);
		chk_word("caps byte write", 32'h0001_ff00, got);
		wr_reg(1'b1, OFF_SLOT_CAP, 4'h0, 32'hffff_ffff);
		chk_bit("sideband message", 1'b0, seen_spl);
		rd_reg(OFF_SLOT_CAP);
		chk_word("caps sideband", 32'hfff9_fffb, got);
		chk_word("upstream sideband", 32'h0, got_up);
		wr_reg(1'b1, OFF_LINK_STATE, 4'h0, 32'h0);
		rd_reg(OFF_LINK_STATE);
		chk_word("clock override", lw(4'b0000, 6'h02, 4'h2), got);
		// second reset must restore strap level and drop sideband loads
		@(posedge mclk);
		reset <= 1'b1;
		strap <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		strap <= 1'b0;
		rd_reg(OFF_LINK_STATE);
		chk_word("link second reset", lw(4'b0100, 6'h01, 4'h2), got);
		rd_reg(OFF_SLOT_CAP);
		chk_word("caps second reset", 32'h0, got);
		conclude();
	end
endmodule
